// ==== logic/uim_mask_stage.sv ====
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Serial port interrupt masking stage with an AXI4-Lite register slave
module uim_mask_stage #(
  parameter int NSRC = uim_pkg::NSRC
) (
  input  wire logic        aclk,          // System clock, 200 MHz
  input  wire logic        aresetn,       // Synchronous reset, active low
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,  // Write byte address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte lane strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,  // Read byte address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  // Interrupt sources and destinations
  input  wire logic [NSRC-1:0] raw_irq,   // Raw causes, rx at bit 0
  output logic [NSRC-1:0]  masked_irq,    // Forwarded to controller
  output logic             irq            // Level, unmasked sticky event
);

  // Expand byte strobes to a per-bit write enable
  function automatic logic [31:0] strb_bits(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Place a source vector at its field position in a word
  function automatic logic [31:0] to_word(input logic [NSRC-1:0] v);
    logic [31:0] w;
    w = uim_pkg::WORD_ZERO;
    w[uim_pkg::SRC_LO +: NSRC] = v;
    return w;
  endfunction

  // ---------------- Write channel ----------------
  logic [11:0]     awaddr_r;
  logic [11:0]     awaddr_nxt;
  logic            aw_full_r;
  logic            aw_full_nxt;
  logic [31:0]     wdata_r;
  logic [31:0]     wdata_nxt;
  logic [3:0]      wstrb_r;
  logic [3:0]      wstrb_nxt;
  logic            w_full_r;
  logic            w_full_nxt;
  logic            awready_r;
  logic            wready_r;
  logic            bvalid_r;
  logic            bvalid_nxt;
  logic [1:0]      bresp_r;
  logic [1:0]      bresp_nxt;

  // Address and data may arrive in either order; the write waits for both
  wire             aw_hs     = s_axi_awvalid & awready_r;
  wire             w_hs      = s_axi_wvalid & wready_r;
  wire             do_wr     = aw_full_r & w_full_r & ~bvalid_r;
  wire             b_hs      = bvalid_r & s_axi_bready;
  wire [31:0]      wbits     = strb_bits(wstrb_r);
  wire             wr_mask   = do_wr & (awaddr_r == uim_pkg::OFS_MASK);
  wire             wr_sticky = do_wr & (awaddr_r == uim_pkg::OFS_STICKY);
  wire             wr_ro     = do_wr &
                               ((awaddr_r == uim_pkg::OFS_RAW) |
                                (awaddr_r == uim_pkg::OFS_MASKED));
  wire             wr_hit    = wr_mask | wr_sticky | wr_ro;

  assign awaddr_nxt  = aw_hs ? s_axi_awaddr : awaddr_r;
  assign aw_full_nxt = (aw_full_r | aw_hs) & ~do_wr;
  assign wdata_nxt   = w_hs ? s_axi_wdata : wdata_r;
  assign wstrb_nxt   = w_hs ? s_axi_wstrb : wstrb_r;
  assign w_full_nxt  = (w_full_r | w_hs) & ~do_wr;
  assign bvalid_nxt  = do_wr | (bvalid_r & ~b_hs);
  assign bresp_nxt   = do_wr ? (wr_hit ? uim_pkg::RESP_OKAY
                                       : uim_pkg::RESP_SLVERR)
                             : bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r  <= 12'h000;
      aw_full_r <= 1'b0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      w_full_r  <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= uim_pkg::RESP_OKAY;
    end else begin
      awaddr_r  <= awaddr_nxt;
      aw_full_r <= aw_full_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r  <= ~w_full_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
    end
  end

  // ---------------- Mask register ----------------
  logic [NSRC-1:0] mask_r;
  logic [NSRC-1:0] mask_nxt;

  wire [NSRC-1:0]  mask_we  = wbits[uim_pkg::SRC_LO +: NSRC];
  wire [NSRC-1:0]  mask_wd  = wdata_r[uim_pkg::SRC_LO +: NSRC];

  // Only bits 10:4 are stored; bits 3:0 and 31:11 are dropped
  assign mask_nxt = wr_mask ? ((mask_r & ~mask_we) | (mask_wd & mask_we))
                            : mask_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= uim_pkg::MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ---------------- Sticky events and forwarding ----------------
  logic [NSRC-1:0] sticky;
  logic [NSRC-1:0] masked_q;
  logic            any_q;

  // Write-one-to-clear; a raw cause in the same cycle keeps its bit set
  wire [NSRC-1:0]  sticky_clr = wr_sticky ? (mask_wd & mask_we)
                                          : '0;

  uim_src_gate #(
    .N       (NSRC)
  ) u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw     (raw_irq),
    .enable  (mask_r),
    .clear   (sticky_clr),
    .sticky  (sticky),
    .masked  (masked_q),
    .any_irq (any_q)
  );

  // ---------------- Read channel ----------------
  logic            arready_r;
  logic            arready_nxt;
  logic            rvalid_r;
  logic            rvalid_nxt;
  logic [31:0]     rdata_r;
  logic [31:0]     rdata_nxt;
  logic [1:0]      rresp_r;
  logic [1:0]      rresp_nxt;

  // Read data are captured at the address handshake and then held
  wire             ar_hs  = s_axi_arvalid & arready_r;
  wire             r_hs   = rvalid_r & s_axi_rready;
  wire             rd_msk = s_axi_araddr == uim_pkg::OFS_MASK;
  wire             rd_raw = s_axi_araddr == uim_pkg::OFS_RAW;
  wire             rd_mkd = s_axi_araddr == uim_pkg::OFS_MASKED;
  wire             rd_stk = s_axi_araddr == uim_pkg::OFS_STICKY;
  wire             rd_hit = rd_msk | rd_raw | rd_mkd | rd_stk;

  // Reserved bits of every word read as zero
  wire [31:0]      rd_word =
    rd_msk ? to_word(mask_r) :
    rd_raw ? to_word(raw_irq) :
    rd_mkd ? to_word(masked_q) :
    rd_stk ? to_word(sticky) :
             uim_pkg::WORD_ZERO;

  assign arready_nxt = ar_hs ? 1'b0 : (r_hs | (arready_r | ~rvalid_r));
  assign rvalid_nxt  = ar_hs | (rvalid_r & ~r_hs);
  assign rdata_nxt   = ar_hs ? rd_word : rdata_r;
  assign rresp_nxt   = ar_hs ? (rd_hit ? uim_pkg::RESP_OKAY
                                       : uim_pkg::RESP_SLVERR)
                             : rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= uim_pkg::WORD_ZERO;
      rresp_r   <= uim_pkg::RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // ---------------- Outputs ----------------
  // Every output is a flip-flop; no input reaches a pin directly
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign masked_irq    = masked_q;
  assign irq           = any_q;

endmodule // uim_mask_stage

// ==== logic/uim_pkg.sv ====
// How it works
// - Overrun mask bit is read/write, reads back, 1 passes overrun interrupt onward.
// - Break mask at bit 9, read/write, resets 0, 1 passes break interrupt.
// - Parity mask at bit 8, read/write, resets 0, 1 passes parity interrupt.
// - Receive mask bit reads back; writing 1 lets receive interrupt through.
// - Bits 3:0 read-only zero; software keeps them on read-modify-write.
// - A 0 mask withholds the interrupt while the raw condition stays recorded.
// - Overrun mask at bit 10, resets 0; bits 31:11 read as zero.
package uim_pkg;

  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          NSRC        = 7;

  // Register byte addresses
  localparam logic [11:0] OFS_MASK    = 12'h038;
  localparam logic [11:0] OFS_RAW     = 12'h03C;
  localparam logic [11:0] OFS_MASKED  = 12'h040;
  localparam logic [11:0] OFS_STICKY  = 12'h044;

  // Field layout of every status and mask word
  localparam int          SRC_LO      = 4;
  localparam int          SRC_HI      = 10;
  localparam int          BIT_RX      = 4;
  localparam int          BIT_TX      = 5;
  localparam int          BIT_RT      = 6;
  localparam int          BIT_FE      = 7;
  localparam int          BIT_PE      = 8;
  localparam int          BIT_BE      = 9;
  localparam int          BIT_OE      = 10;

  localparam logic [6:0]  MASK_RESET  = 7'h00;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

// ==== logic/uim_src_gate.sv ====
`timescale 1ns/1ps
// Per-source sticky status, forwarding gate and summary interrupt
module uim_src_gate #(
  parameter int N = 7
) (
  input  wire logic         aclk,      // System clock
  input  wire logic         aresetn,   // Synchronous reset, active low
  input  wire logic [N-1:0] raw,       // Raw interrupt conditions
  input  wire logic [N-1:0] enable,    // Mask bits, 1 forwards
  input  wire logic [N-1:0] clear,     // One-cycle write-one-to-clear
  output logic      [N-1:0] sticky,    // Latched events
  output logic      [N-1:0] masked,    // Raw gated by enable
  output logic              any_irq    // Unmasked sticky event pending
);

  logic [N-1:0] sticky_nxt;
  logic [N-1:0] masked_nxt;
  logic         any_nxt;

  // A raw condition present in the clearing cycle survives the clear
  assign sticky_nxt = (sticky & ~clear) | raw;
  assign masked_nxt = raw & enable;
  assign any_nxt    = |(sticky & enable);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sticky  <= '0;
      masked  <= '0;
      any_irq <= 1'b0;
    end else begin
      sticky  <= sticky_nxt;
      masked  <= masked_nxt;
      any_irq <= any_nxt;
    end
  end

endmodule // uim_src_gate

// ==== testbench/uim_irq_sink.sv ====
`timescale 1ns/1ps
// Controller side: latches every forwarded cause until cleared
module uim_irq_sink (
  input  wire logic       aclk,    // Clock
  input  wire logic       aresetn, // Reset, active low
  input  wire logic       clr,     // Forget latched causes
  input  wire logic [6:0] irq_in,  // Forwarded causes
  output logic      [6:0] seen     // Causes seen since clr
);
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) seen <= 7'h00;
    else seen <= seen | irq_in;
  end
endmodule // uim_irq_sink

// ==== testbench/uim_mask_stage_assertions.sv ====
`timescale 1ns/1ps
module uim_mask_stage_assertions #(
  parameter int NSRC = 7
) (
  input wire logic            aclk,          // Clock
  input wire logic            aresetn,       // Reset
  input wire logic [NSRC-1:0] raw_irq,       // Raw causes
  input wire logic [NSRC-1:0] masked_irq,    // Forwarded
  input wire logic            irq,           // Summary
  input wire logic            s_axi_bvalid,  // B valid
  input wire logic            s_axi_bready,  // B ready
  input wire logic            s_axi_arvalid, // AR valid
  input wire logic            s_axi_arready, // AR ready
  input wire logic [31:0]     s_axi_rdata,   // R data
  input wire logic [1:0]      s_axi_rresp,   // R resp
  input wire logic            s_axi_rvalid,  // R valid
  input wire logic            s_axi_rready   // R ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fwd_only_raw_a: assert property (
    (masked_irq & ~$past(raw_irq)) == '0) else $error("forward w/o raw");
  rsv_read_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp == uim_pkg::RESP_OKAY |->
    s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:11] == 21'h0)
    else $error("reserved bits set");
  read_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late r");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
  ar_blocked_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  irq_follow_a: assert property (
    (masked_irq & $past(masked_irq)) != '0 |-> irq)
    else $error("irq missing");
  reset_quiet_a: assert property ($rose(aresetn) |->
    !irq && masked_irq == '0 && !s_axi_rvalid) else $error("reset state");
endmodule // uim_mask_stage_assertions
bind uim_mask_stage uim_mask_stage_assertions #(.NSRC(NSRC)) u_chk (
  .aclk, .aresetn, .raw_irq, .masked_irq, .irq, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ==== testbench/uim_mask_stage_tb.sv ====
`timescale 1ns/1ps
module uim_mask_stage_tb;
  logic        aclk, aresetn, clr, irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [6:0]  raw_irq, masked_irq, seen;
  int          fails, samples_checked;
  uim_mask_stage DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .raw_irq, .masked_irq,
    .irq);
  uim_irq_sink u_sink (.aclk, .aresetn, .clr, .irq_in(masked_irq), .seen);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic t_rw;
    rd(uim_pkg::OFS_MASK, 32'h0, uim_pkg::RESP_OKAY);
    wr(uim_pkg::OFS_MASK, 32'hFFFF_FFFF, 4'hF, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_MASK, 32'h7F0, uim_pkg::RESP_OKAY);
    wr(uim_pkg::OFS_MASK, 32'h0, 4'h1, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_MASK, 32'h700, uim_pkg::RESP_OKAY);
    wr(12'h100, 32'hFFFF_FFFF, 4'hF, uim_pkg::RESP_SLVERR);
    rd(12'h100, 32'h0, uim_pkg::RESP_SLVERR);
    wr(uim_pkg::OFS_RAW, 32'hFFFF_FFFF, 4'hF, uim_pkg::RESP_OKAY);
    wr(uim_pkg::OFS_MASKED, 32'hFFFF_FFFF, 4'hF, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_MASK, 32'h700, uim_pkg::RESP_OKAY);
  endtask
  // Each cause alone enabled while every raw line is high
  task automatic t_fwd;
    for (int i = 0; i < 7; i++) begin
      wr(uim_pkg::OFS_MASK, 32'h10 << i, 4'hF, uim_pkg::RESP_OKAY);
      @(posedge aclk);
      raw_irq <= 7'h7F;
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      @(posedge aclk);
      #1;
      check({25'h0, masked_irq}, 32'h1 << i);
      check({25'h0, seen}, 32'h1 << i);
      check({31'h0, irq}, 32'h1);
      @(posedge aclk);
      raw_irq <= 7'h00;
      wr(uim_pkg::OFS_STICKY, 32'hFFFF_FFFF, 4'hF, uim_pkg::RESP_OKAY);
      repeat (2) @(posedge aclk);
      check({31'h0, irq}, 32'h0);
    end
  endtask
  // Blocked cause stays recorded and fires once enabled
  task automatic t_held;
    wr(uim_pkg::OFS_MASK, 32'h0, 4'hF, uim_pkg::RESP_OKAY);
    @(posedge aclk);
    raw_irq <= 7'h40;
    wr(uim_pkg::OFS_STICKY, 32'h400, 4'hF, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_STICKY, 32'h400, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_RAW, 32'h400, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_MASKED, 32'h0, uim_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    raw_irq <= 7'h00;
    check({24'h0, irq, masked_irq}, 32'h0);
    wr(uim_pkg::OFS_MASK, 32'h400, 4'hF, uim_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    wr(uim_pkg::OFS_STICKY, 32'h400, 4'hF, uim_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    check({31'h0, irq}, 32'h0);
  endtask
  // Reset in mid-run clears mask, sticky state and both interrupt outputs
  task automatic t_reset;
    wr(uim_pkg::OFS_MASK, 32'h7F0, 4'hF, uim_pkg::RESP_OKAY);
    @(posedge aclk);
    raw_irq <= 7'h7F;
    repeat (3) @(posedge aclk);
    check({31'h0, irq}, 32'h1);
    aresetn <= 1'b0;
    raw_irq <= 7'h00;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check({24'h0, irq, masked_irq}, 32'h0);
    rd(uim_pkg::OFS_MASK, 32'h0, uim_pkg::RESP_OKAY);
    rd(uim_pkg::OFS_STICKY, 32'h0, uim_pkg::RESP_OKAY);
  endtask
  initial begin
    #20000;
    fails++;
    summarize();
  end
  initial begin
    fails = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    clr = 1'b0;
    raw_irq = 7'h00;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    check({24'h0, irq, masked_irq}, 32'h0);
    t_rw();
    t_fwd();
    t_held();
    t_reset();
    summarize();
  end
endmodule // uim_mask_stage_tb
